// [rtl/ierb_pkg.sv]
// constants for the interrupt enable and request bank
`default_nettype none

package ierb_pkg;
   // wishbone word addressing: byte address is four times the register index
   localparam int ADR_W = 20;
   localparam int IDX_W = 18;
   localparam int DAT_W = 32;
   localparam int REG_W = 16;

   localparam logic [IDX_W-1:0] IDX_EXT_EN = 18'h0F010;
   localparam logic [IDX_W-1:0] IDX_T8_EN = 18'h0F014;
   localparam logic [IDX_W-1:0] IDX_TT_EN = 18'h0F016;
   localparam logic [IDX_W-1:0] IDX_REQ = 18'h0F018;
   localparam logic [IDX_W-1:0] IDX_MST_EN = 18'h0F0F0;
   localparam logic [IDX_W-1:0] IDX_ISTAT = 18'h0F0F2;
   localparam logic [IDX_W-1:0] IDX_IEN = 18'h0F0F4;
   localparam logic [IDX_W-1:0] IDX_ICLR = 18'h0F0F6;

   // field positions
   localparam int T8_LSB = 10;
   localparam int T8_N = 6;
   localparam int T16_LSB = 0;
   localparam int T16_N = 4;
   localparam int TB_LSB = 8;
   localparam int TB_N = 3;
   localparam int WDT_BIT = 0;
   localparam int EXT_LSB = 8;
   localparam int EXT_N = 8;
   localparam int EXT_EN_LSB = 8;
   localparam int MST_EN_BIT = 0;

   // implemented bits of each register
   localparam logic [REG_W-1:0] T8_MASK = 16'hFC00;
   localparam logic [REG_W-1:0] TT_MASK = 16'h070F;
   localparam logic [REG_W-1:0] REQ_MASK = 16'hFF01;
   localparam logic [REG_W-1:0] EXT_EN_MASK = 16'hFF00;
   localparam logic [REG_W-1:0] REG_RST = 16'h0000;

   // sticky status bits
   localparam int ST_WDT = 0;
   localparam int ST_EXT = 1;
   localparam int ST_ACC = 2;
   localparam int ST_N = 3;
   localparam logic [ST_N-1:0] ST_RST = 3'h0;

   // cycles standing for one further instruction after a software-raised request
   localparam int HOLD_W = 4;
   localparam logic [HOLD_W-1:0] HOLDOFF_CYC = 4'h2;
endpackage

`default_nettype wire

// [rtl/ierb_flag.sv]
// one sticky request flag: hardware event or software set, cleared by software or acceptance
`default_nettype none

module ierb_flag (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic evt_in,
   input wire logic wr_set_in,
   input wire logic wr_clr_in,
   input wire logic acc_in,
   output logic q_out,
   output logic nxt_out
);
   logic q_r;

   // a set in the same cycle as any clear wins, so no event is lost
   assign nxt_out = evt_in | wr_set_in | (q_r & ~wr_clr_in & ~acc_in);
   assign q_out = q_r;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q_r <= 1'b0;
      end else begin
         q_r <= nxt_out;
      end
   end
endmodule

`default_nettype wire

// [rtl/ierb_top.sv]
// interrupt enable and request bank with wishbone register access
`default_nettype none

module ierb_top
   import ierb_pkg::*;
#(
   parameter logic [HOLD_W-1:0] HOLDOFF_P = HOLDOFF_CYC
) (
   input wire logic MCLK_IN,
   input wire logic ARST_N_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [ADR_W-1:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [DAT_W-1:0] WB_DAT_IN,
   output logic [DAT_W-1:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   input wire logic WDT_EVT_IN,
   input wire logic [EXT_N-1:0] EXT_EVT_IN,
   input wire logic CPU_ACC_IN,
   input wire logic CPU_ACC_WDT_IN,
   input wire logic [EXT_N-1:0] CPU_ACC_EXT_IN,
   output logic WDT_REQ_OUT,
   output logic [EXT_N-1:0] EXT_REQ_OUT,
   output logic MASTER_EN_OUT,
   output logic [T8_N-1:0] TIMER8_EN_OUT,
   output logic [T16_N-1:0] TIMER16_EN_OUT,
   output logic [TB_N-1:0] TIMEBASE_EN_OUT,
   output logic IRQ_OUT
);
   logic rst_meta_r;
   logic rst_n_r;
   logic ack_r;
   logic [DAT_W-1:0] dat_r;
   logic [REG_W-1:0] t8_en_r;
   logic [REG_W-1:0] tt_en_r;
   logic [REG_W-1:0] ext_en_r;
   logic mst_en_r;
   logic mst_en_nxt;
   logic [ST_N-1:0] ist_r;
   logic [ST_N-1:0] ien_r;
   logic [ST_N-1:0] ev;
   logic [ST_N-1:0] iclr;
   logic irq_r;
   logic [HOLD_W-1:0] hold_r;
   logic [HOLD_W-1:0] hold_nxt;
   logic wdt_req_r;
   logic [EXT_N-1:0] ext_req_r;
   logic req_v;
   logic wr_commit;
   logic [IDX_W-1:0] idx;
   logic [REG_W-1:0] lane;
   logic [REG_W-1:0] wdat;
   logic [REG_W-1:0] rd_mux;
   logic hit_t8;
   logic hit_tt;
   logic hit_req;
   logic hit_ext;
   logic hit_mst;
   logic hit_ien;
   logic hit_iclr;
   logic acc_any;
   logic [EXT_N:0] flag_q;
   logic [EXT_N:0] flag_nxt;
   logic [EXT_N:0] evt_vec;
   logic [EXT_N:0] acc_vec;
   logic [EXT_N:0] wbit;
   logic [EXT_N:0] wlane;

   // reset is released through two flops; only the second one is used
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // bus decode
   assign req_v = WB_CYC_IN & WB_STB_IN;
   assign idx = WB_ADR_IN[ADR_W-1:2];
   // writes land at the edge where ack is seen high, as the master samples it
   assign wr_commit = req_v & WB_WE_IN & ack_r;
   assign lane = {{8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
   assign wdat = WB_DAT_IN[REG_W-1:0];
   assign hit_t8 = (idx == IDX_T8_EN);
   assign hit_tt = (idx == IDX_TT_EN);
   assign hit_req = (idx == IDX_REQ);
   assign hit_ext = (idx == IDX_EXT_EN);
   assign hit_mst = (idx == IDX_MST_EN);
   assign hit_ien = (idx == IDX_IEN);
   assign hit_iclr = (idx == IDX_ICLR);

   always_comb begin
      rd_mux = REG_RST;
      if (hit_t8) begin
         rd_mux = t8_en_r;
      end else if (hit_tt) begin
         rd_mux = tt_en_r;
      end else if (hit_req) begin
         rd_mux = {flag_q[EXT_N:1], 7'h00, flag_q[0]};
      end else if (hit_ext) begin
         rd_mux = ext_en_r;
      end else if (hit_mst) begin
         rd_mux = {15'h0000, mst_en_r};
      end else if (hit_ien) begin
         rd_mux = {13'h0000, ien_r};
      end else if (idx == IDX_ISTAT) begin
         rd_mux = {13'h0000, ist_r};
      end
   end

   // one wait state: ack rises the cycle after the request, drops the next
   always_ff @(posedge MCLK_IN or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req_v & ~ack_r;
      end
   end

   // unmapped addresses are acked and read as zero
   always_ff @(posedge MCLK_IN or negedge rst_n_r) begin
      if (!rst_n_r) begin
         dat_r <= 32'h00000000;
      end else if (req_v & ~ack_r) begin
         dat_r <= {16'h0000, rd_mux};
      end
   end

   // enable registers; only implemented bits hold state
   always_ff @(posedge MCLK_IN or negedge rst_n_r) begin
      if (!rst_n_r) begin
         t8_en_r <= REG_RST;
      end else if (wr_commit & hit_t8) begin
         t8_en_r <= (t8_en_r & ~(lane & T8_MASK)) | (wdat & lane & T8_MASK);
      end
   end

   always_ff @(posedge MCLK_IN or negedge rst_n_r) begin
      if (!rst_n_r) begin
         tt_en_r <= REG_RST;
      end else if (wr_commit & hit_tt) begin
         tt_en_r <= (tt_en_r & ~(lane & TT_MASK)) | (wdat & lane & TT_MASK);
      end
   end

   always_ff @(posedge MCLK_IN or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ext_en_r <= REG_RST;
      end else if (wr_commit & hit_ext) begin
         ext_en_r <= (ext_en_r & ~(lane & EXT_EN_MASK)) | (wdat & lane & EXT_EN_MASK);
      end
   end

   // master enable: acceptance beats a software set in the same cycle
   assign acc_any = CPU_ACC_IN | CPU_ACC_WDT_IN | (|CPU_ACC_EXT_IN);

   always_comb begin
      mst_en_nxt = mst_en_r;
      if (acc_any) begin
         mst_en_nxt = 1'b0;
      end else if (wr_commit & hit_mst & WB_SEL_IN[0]) begin
         mst_en_nxt = wdat[MST_EN_BIT];
      end
   end

   always_ff @(posedge MCLK_IN or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mst_en_r <= 1'b0;
      end else begin
         mst_en_r <= mst_en_nxt;
      end
   end

   // request flags: index 0 is the watchdog, 1..8 the external inputs
   assign evt_vec = {EXT_EVT_IN, WDT_EVT_IN};
   assign acc_vec = {CPU_ACC_EXT_IN, CPU_ACC_WDT_IN};
   assign wbit = {wdat[EXT_LSB +: EXT_N], wdat[WDT_BIT]};
   assign wlane = {{EXT_N{wr_commit & hit_req & WB_SEL_IN[1]}},
      wr_commit & hit_req & WB_SEL_IN[0]};

   genvar gi;
   generate
      for (gi = 0; gi <= EXT_N; gi++) begin : g_flag
         ierb_flag u_flag (
            .clk_in(MCLK_IN),
            .rst_n_in(rst_n_r),
            .evt_in(evt_vec[gi]),
            .wr_set_in(wlane[gi] & wbit[gi]),
            .wr_clr_in(wlane[gi] & ~wbit[gi]),
            .acc_in(acc_vec[gi]),
            .q_out(flag_q[gi]),
            .nxt_out(flag_nxt[gi])
         );
      end
   endgenerate

   // a software write to the request or external enable register holds off delivery, standing
   // in for the one instruction the cpu executes before its transfer cycle
   always_comb begin
      hold_nxt = hold_r;
      if (wr_commit & (hit_req | hit_ext)) begin
         hold_nxt = HOLDOFF_P;
      end else if (hold_r != 4'h0) begin
         hold_nxt = hold_r - 4'h1;
      end
   end

   always_ff @(posedge MCLK_IN or negedge rst_n_r) begin
      if (!rst_n_r) begin
         hold_r <= 4'h0;
      end else begin
         hold_r <= hold_nxt;
      end
   end

   // requests built from next-state values so acceptance drops them at once
   always_ff @(posedge MCLK_IN or negedge rst_n_r) begin
      if (!rst_n_r) begin
         wdt_req_r <= 1'b0;
      end else begin
         wdt_req_r <= flag_nxt[0] & (hold_nxt == 4'h0);
      end
   end

   // external enables are taken as registered, so a new one shows one cycle later; master enable is taken at its next value
   always_ff @(posedge MCLK_IN or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ext_req_r <= 8'h00;
      end else begin
         ext_req_r <= flag_nxt[EXT_N:1] & ext_en_r[EXT_EN_LSB +: EXT_N] & {EXT_N{mst_en_nxt}}
            & {EXT_N{hold_nxt == 4'h0}};
      end
   end

   // block interrupt: sticky status, enable, write-one-to-clear register
   assign ev[ST_WDT] = flag_nxt[0] & ~flag_q[0];
   assign ev[ST_EXT] = |(flag_nxt[EXT_N:1] & ~flag_q[EXT_N:1]);
   assign ev[ST_ACC] = acc_any;
   assign iclr = {ST_N{wr_commit & hit_iclr & WB_SEL_IN[0]}} & wdat[ST_N-1:0];

   always_ff @(posedge MCLK_IN or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ist_r <= ST_RST;
      end else begin
         ist_r <= (ist_r & ~iclr) | ev;
      end
   end

   always_ff @(posedge MCLK_IN or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ien_r <= ST_RST;
      end else if (wr_commit & hit_ien & WB_SEL_IN[0]) begin
         ien_r <= wdat[ST_N-1:0];
      end
   end

   always_ff @(posedge MCLK_IN or negedge rst_n_r) begin
      if (!rst_n_r) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(ist_r & ien_r);
      end
   end

   assign WB_ACK_OUT = ack_r;
   assign WB_DAT_OUT = dat_r;
   assign WDT_REQ_OUT = wdt_req_r;
   assign EXT_REQ_OUT = ext_req_r;
   assign MASTER_EN_OUT = mst_en_r;
   assign TIMER8_EN_OUT = t8_en_r[T8_LSB +: T8_N];
   assign TIMER16_EN_OUT = tt_en_r[T16_LSB +: T16_N];
   assign TIMEBASE_EN_OUT = tt_en_r[TB_LSB +: TB_N];
   assign IRQ_OUT = irq_r;

   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (!rst_n_r);

   chk_master_cleared: assert property (
      acc_any |=> !mst_en_r)
      else $error("master enable not cleared on acceptance");

   chk_enables_kept: assert property (
      (acc_any && !wr_commit) |=> $stable(tt_en_r) && $stable(ext_en_r) && $stable(t8_en_r))
      else $error("individual enables changed on acceptance");

   chk_wdt_unmasked: assert property (
      (flag_q[0] && hold_r == 4'h0) |-> WDT_REQ_OUT)
      else $error("pending watchdog not presented");

   chk_wdt_evt_sets: assert property (
      WDT_EVT_IN |=> flag_q[0])
      else $error("watchdog event did not set its flag");

   chk_ext_evt_sets: assert property (
      (|EXT_EVT_IN) |=> ((flag_q[EXT_N:1] & $past(EXT_EVT_IN)) == $past(EXT_EVT_IN)))
      else $error("external event did not set its flag");

   chk_ext_gating: assert property (
      ((EXT_REQ_OUT & ~flag_q[EXT_N:1]) == 8'h00) && (EXT_REQ_OUT == 8'h00 || mst_en_r))
      else $error("external request without flag or master enable");

   chk_sw_set: assert property (
      (wr_commit && hit_req && WB_SEL_IN[1] && WB_DAT_IN[EXT_LSB]) |=> flag_q[1])
      else $error("software set of request flag lost");

   chk_accept_clears: assert property (
      (CPU_ACC_EXT_IN[0] && !EXT_EVT_IN[0] && !wr_commit) |=> !flag_q[1] && !EXT_REQ_OUT[0])
      else $error("accepted request flag not cleared");

   chk_sw_holdoff: assert property (
      (wr_commit && hit_req) |=> !WDT_REQ_OUT [*2])
      else $error("software request presented without holdoff");

   chk_ack_single: assert property (
      WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("ack held longer than one cycle");

   chk_req_unused: assert property (
      (req_v && !ack_r && hit_req) |=> (WB_DAT_OUT[7:1] == 7'h00))
      else $error("unused request bits read nonzero");
endmodule

`default_nettype wire

// [verification/ierb_cpu_model.sv]
// cpu-side model: takes presented requests after a programmable delay
`default_nettype none

module ierb_cpu_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic en_in,
   input wire logic [3:0] dly_in,
   input wire logic wdt_req_in,
   input wire logic [7:0] ext_req_in,
   output logic acc_out,
   output logic acc_wdt_out,
   output logic [7:0] acc_ext_out
);
   logic [3:0] cnt_r;
   logic [7:0] pick;

   // lowest numbered external wins; the watchdog beats them all
   assign pick = ext_req_in & (~ext_req_in + 8'h01);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_r <= 4'h0;
         acc_out <= 1'b0;
         acc_wdt_out <= 1'b0;
         acc_ext_out <= 8'h00;
      end else if (acc_out || !en_in || !(wdt_req_in || (|ext_req_in))) begin
         // one idle cycle after a grant lets the cleared flag reach us
         cnt_r <= 4'h0;
         acc_out <= 1'b0;
         acc_wdt_out <= 1'b0;
         acc_ext_out <= 8'h00;
      end else if (cnt_r == dly_in) begin
         cnt_r <= 4'h0;
         acc_out <= 1'b1;
         acc_wdt_out <= wdt_req_in;
         acc_ext_out <= wdt_req_in ? 8'h00 : pick;
      end else begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
endmodule

`default_nettype wire

// [verification/tb.sv]
// self-checking bench for the interrupt enable and request bank
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ierb_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, wdt_evt = 1'b0, acc, acc_wdt;
   logic [ADR_W-1:0] adr = '0;
   logic [3:0] sel = 4'h0;
   logic [DAT_W-1:0] dat = '0, rdat;
   logic [7:0] ext_evt = 8'h00, acc_ext, ext_req;
   logic wdt_req, mst_en, irq, m_en = 1'b0;
   logic [5:0] t8;
   logic [3:0] t16;
   logic [2:0] tbe;
   int errors = 0;
   int checked = 0;

   always #5 clk = ~clk;

   ierb_top dut (.MCLK_IN(clk), .ARST_N_IN(arst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat), .WB_DAT_OUT(rdat),
      .WB_ACK_OUT(ack), .WDT_EVT_IN(wdt_evt), .EXT_EVT_IN(ext_evt), .CPU_ACC_IN(acc),
      .CPU_ACC_WDT_IN(acc_wdt), .CPU_ACC_EXT_IN(acc_ext), .WDT_REQ_OUT(wdt_req),
      .EXT_REQ_OUT(ext_req), .MASTER_EN_OUT(mst_en), .TIMER8_EN_OUT(t8), .TIMER16_EN_OUT(t16),
      .TIMEBASE_EN_OUT(tbe), .IRQ_OUT(irq));

   ierb_cpu_model cpu (.clk_in(clk), .rst_n_in(arst_n), .en_in(m_en), .dly_in(4'h4),
      .wdt_req_in(wdt_req), .ext_req_in(ext_req), .acc_out(acc), .acc_wdt_out(acc_wdt),
      .acc_ext_out(acc_ext));

   task automatic give_verdict;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: %s got %h", $time, m, got);
      end
   endtask

   // classic single cycle; request held until ack is sampled high
   task automatic bus(input logic w, input logic [IDX_W-1:0] idx, input logic [1:0] s,
         input logic [15:0] d, output logic [15:0] q);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= {2'b00, s};
      dat <= {16'h0000, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) begin
         errors++;
         $display("CHECK FAILED at %0t: no ack", $time);
         give_verdict();
      end
   endtask

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [1:0] s, input logic [15:0] d);
      logic [15:0] q;
      bus(1'b1, idx, s, d, q);
      #1;
   endtask

   task automatic rd(input logic [IDX_W-1:0] idx, input logic [15:0] e, input string m);
      logic [15:0] q;
      bus(1'b0, idx, 2'b11, 16'h0000, q);
      chk(q, e, m);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic evt(input logic w, input logic [7:0] e);
      @(posedge clk);
      wdt_evt <= w;
      ext_evt <= e;
      @(posedge clk);
      wdt_evt <= 1'b0;
      ext_evt <= 8'h00;
      #1;
   endtask

   initial begin
      #200us;
      errors++;
      $display("CHECK FAILED at %0t: run too long", $time);
      give_verdict();
   end

   initial begin
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(IDX_TT_EN, REG_RST, "tt reset");
      rd(IDX_REQ, REG_RST, "req reset");
      rd(IDX_EXT_EN, REG_RST, "ext en reset");
      rd(IDX_T8_EN, REG_RST, "t8 reset");
      wr(18'h00001, 2'b11, 16'hFFFF);
      rd(18'h00001, 16'h0000, "unmapped");
      wr(IDX_T8_EN, 2'b11, 16'hFFFF);
      rd(IDX_T8_EN, T8_MASK, "t8 rw");
      chk(16'(t8), 16'h003F, "t8 out");
      wr(IDX_TT_EN, 2'b11, 16'hFFFF);
      rd(IDX_TT_EN, TT_MASK, "tt rw");
      chk(16'(t16), 16'h000F, "t16 out");
      chk(16'(tbe), 16'h0007, "tb out");
      wr(IDX_TT_EN, 2'b01, 16'h0000);
      rd(IDX_TT_EN, 16'h0700, "tt low byte");
      wr(IDX_TT_EN, 2'b10, 16'h0500);
      rd(IDX_TT_EN, 16'h0500, "tt high byte");
      wr(IDX_REQ, 2'b10, 16'hFFFF);
      rd(IDX_REQ, 16'hFF00, "ext sw set");
      chk(16'(ext_req), 16'h0000, "ext masked");
      wr(IDX_REQ, 2'b10, 16'h0000);
      wr(IDX_REQ, 2'b01, 16'h00FF);
      chk(16'(wdt_req), 16'h0000, "wdt holdoff");
      tick(4);
      chk(16'(wdt_req), 16'h0001, "wdt sw req");
      rd(IDX_REQ, 16'h0001, "wdt bits");
      m_en <= 1'b1;
      tick(10);
      rd(IDX_REQ, 16'h0000, "wdt taken");
      evt(1'b1, 8'h00);
      chk(16'(wdt_req), 16'h0001, "wdt evt");
      tick(10);
      rd(IDX_REQ, 16'h0000, "wdt evt taken");
      wr(IDX_EXT_EN, 2'b10, 16'hFF00);
      for (int i = 0; i < EXT_N; i++) begin
         evt(1'b0, 8'h01 << i);
         rd(IDX_REQ, 16'h0100 << i, "ext evt");
         wr(IDX_MST_EN, 2'b01, 16'h0001);
         chk(16'(mst_en), 16'h0001, "master enable set");
         tick(2);
         chk(16'(ext_req), 16'h0001 << i, "ext req");
         tick(8);
         rd(IDX_REQ, 16'h0000, "ext taken");
         chk(16'(mst_en), 16'h0000, "master enable cleared");
      end
      rd(IDX_TT_EN, 16'h0500, "enables kept");
      wr(IDX_IEN, 2'b01, 16'h0007);
      tick(2);
      chk(16'(irq), 16'h0001, "irq on");
      rd(IDX_ISTAT, 16'h0007, "status");
      wr(IDX_IEN, 2'b01, 16'h0000);
      tick(2);
      chk(16'(irq), 16'h0000, "irq masked");
      wr(IDX_ICLR, 2'b01, 16'h0007);
      rd(IDX_ISTAT, 16'h0000, "status cleared");
      rd(IDX_ICLR, 16'h0000, "clear reads zero");
      give_verdict();
   end
endmodule

`default_nettype wire
